// ==== verilog/mrb_builder.sv ====
`timescale 1ns/1ns
// composes calibration and general records onto the write stream and checks
// records arriving from the read path
module mrb_builder (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // record stream to the write path
  output logic             out_valid,
  output logic [7:0]       out_data,
  output logic             out_last,
  input  wire logic        out_ready,
  // record stream from the read path
  input  wire logic        in_valid,
  input  wire logic [7:0]  in_data,
  input  wire logic        in_last
);
  // software-visible state
  logic [31:0] cal_addr [mrb_pkg::CAL_WORDS];
  logic        flex_on;
  logic        gen_sel;
  logic        rx_gen;
  logic [1:0]  disc_status;
  logic [7:0]  app_code;
  logic [7:0]  phys_code;
  logic [7:0]  part_ext;
  logic [23:0] l0_last;
  logic [23:0] l1_last;
  logic [31:0] mfr1_hi;
  logic [15:0] mfr1_lo;
  logic [31:0] mfr2_hi;
  logic [15:0] mfr2_lo;
  logic [31:0] shift_start;
  logic [5:0]  prerec;
  // checker state
  logic        err_flag;
  logic        err_fmt;
  logic        err_status;
  logic        err_code;
  logic        err_frame;
  logic        chk_done;
  logic [7:0]  rx_fmt_hi;
  logic [7:0]  rx_status;
  logic [7:0]  rx_code;
  // internal wires
  logic        wr_en;
  logic        setup;
  logic        start;
  logic        tx_busy;
  logic [10:0] tx_off;
  logic        advance;
  logic [10:0] rx_off;
  logic        rx_end;
  logic        rx_bad;
  logic [23:0] li_start;
  logic [23:0] mid0_end;
  logic [23:0] mid1_start;
  logic [23:0] mid1_end;
  logic [23:0] lo_start;
  logic [23:0] lo_end;

  // byte of a word, most significant first
  function automatic logic [7:0] be_byte(input logic [31:0] w, input logic [1:0] i);
    be_byte = w[8'(31 - 8 * int'(i)) -: 8]; // RULE21
  endfunction
  // true when an address lies in the calibration word range
  function automatic logic in_cal(input logic [7:0] a);
    in_cal = (a >= mrb_pkg::A_CAL0) && (a <= mrb_pkg::A_CAL6) && (a[1:0] == 2'b00);
  endfunction
  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pready && pwrite;
  assign start   = wr_en && (paddr == mrb_pkg::A_CTRL) && pwdata[mrb_pkg::CTRL_START];
  assign advance = tx_busy && (!out_valid || out_ready);
  // pre-recordable range limits from disc size, burst area and last addresses
  assign li_start   = prerec[mrb_pkg::PRE_NARROW_BURST_CUT_AREA] ? mrb_pkg::LI_START_NB : mrb_pkg::LI_START; // RULE18
  assign mid0_end   = prerec[mrb_pkg::PRE_SMALL] ? mrb_pkg::MID0_END_S : mrb_pkg::MID0_END_L; // RULE19
  assign mid1_start = prerec[mrb_pkg::PRE_SMALL] ? mrb_pkg::MID1_ST_S : mrb_pkg::MID1_ST_L; // RULE19
  assign mid1_end   = ~(l0_last - mrb_pkg::MID_BACK); // RULE19
  assign lo_start   = l1_last - mrb_pkg::LO_BACK; // RULE20
  assign lo_end     = prerec[mrb_pkg::PRE_NARROW_BURST_CUT_AREA] ? mrb_pkg::LO_END_NB : mrb_pkg::LO_END; // RULE20
  // boundary word for a prerecorded zone, zero when the zone is absent
  function automatic logic [31:0] bound_word(input logic [1:0] k);
    case (k)
      2'd0:    bound_word = prerec[mrb_pkg::PRE_LEADIN] ? {8'h00, mrb_pkg::LI_END} : 32'h0; // RULE17 RULE18
      2'd1:    bound_word = prerec[mrb_pkg::PRE_MIDDLE] ? {8'h00, mid0_end} : 32'h0; // RULE17
      2'd2:    bound_word = prerec[mrb_pkg::PRE_MIDDLE] ? {8'h00, mid1_start} : 32'h0; // RULE17
      default: bound_word = prerec[mrb_pkg::PRE_LEADOUT] ? {8'h00, lo_start} : 32'h0; // RULE17
    endcase
  endfunction
  // calibration-location record byte at an offset
  function automatic logic [7:0] cal_byte(input logic [10:0] o);
    logic [10:0] r;
    r = o - 11'd1;
    if (o == 11'd0) begin
      cal_byte = flex_on ? mrb_pkg::FLEX_ON : mrb_pkg::FLEX_OFF; // RULE1
    end else if (o <= mrb_pkg::O_CAL_E) begin
      cal_byte = be_byte(cal_addr[r[4:2]], r[1:0]); // RULE2 RULE3 RULE4 RULE5
    end else begin
      cal_byte = 8'h00; // RULE6
    end
  endfunction
  // pre-pit copy byte at an offset inside 22..85, multi-byte fields msb first
  function automatic logic [7:0] prepit_byte(input logic [10:0] o);
    case (o)
      11'd22:  prepit_byte = 8'h01; // RULE11
      11'd23:  prepit_byte = app_code; // RULE12
      11'd24:  prepit_byte = phys_code; // RULE12
      11'd25, 11'd26, 11'd27: prepit_byte = be_byte({8'h00, l0_last}, 2'(o - 11'd24)); // RULE12
      11'd28:  prepit_byte = part_ext; // RULE12
      11'd30:  prepit_byte = 8'h02; // RULE11
      11'd33, 11'd34, 11'd35: prepit_byte = be_byte({8'h00, l1_last}, 2'(o - 11'd32)); // RULE12
      11'd38:  prepit_byte = 8'h03; // RULE11
      11'd39, 11'd40, 11'd41, 11'd42: prepit_byte = be_byte(mfr1_hi, 2'(o - 11'd39)); // RULE12
      11'd43, 11'd44: prepit_byte = be_byte({16'h0, mfr1_lo}, 2'(o - 11'd41));
      11'd46:  prepit_byte = 8'h04; // RULE11
      11'd47, 11'd48, 11'd49, 11'd50: prepit_byte = be_byte(mfr2_hi, 2'(o - 11'd47)); // RULE12
      11'd51, 11'd52: prepit_byte = be_byte({16'h0, mfr2_lo}, 2'(o - 11'd49));
      11'd54:  prepit_byte = 8'h05; // RULE11
      default: prepit_byte = 8'h00; // RULE12
    endcase
  endfunction
  // general disc-information record byte at an offset
  function automatic logic [7:0] gen_byte(input logic [10:0] o);
    logic [10:0] b;
    logic [10:0] s;
    b = o - mrb_pkg::O_BOUND;
    s = o - mrb_pkg::O_SHIFT;
    if (o == 11'd0) begin
      gen_byte = mrb_pkg::FMT_CODE[15:8]; // RULE7
    end else if (o == 11'd1) begin
      gen_byte = mrb_pkg::FMT_CODE[7:0]; // RULE7
    end else if (o == 11'd2) begin
      gen_byte = {6'h00, disc_status}; // RULE8
    end else if (o < mrb_pkg::O_PREPIT) begin
      gen_byte = 8'h00; // RULE9 RULE10
    end else if (o <= mrb_pkg::O_PREPIT_E) begin
      gen_byte = prepit_byte(o);
    end else if (o < mrb_pkg::O_PRECODE) begin
      gen_byte = prerec[mrb_pkg::PRE_SHIFT] ? be_byte(shift_start, s[1:0]) : 8'h00; // RULE13
    end else if (o == mrb_pkg::O_PRECODE) begin
      gen_byte = {4'h0, prerec[mrb_pkg::PRE_LEADOUT], prerec[mrb_pkg::PRE_MIDDLE],
                  prerec[mrb_pkg::PRE_LEADIN], 1'b0}; // RULE14 RULE15
    end else if (o >= mrb_pkg::O_BOUND && o <= mrb_pkg::O_BOUND_E) begin
      gen_byte = be_byte(bound_word(b[3:2]), b[1:0]); // RULE17
    end else begin
      gen_byte = 8'h00;
    end
  endfunction
  // offset sequencer for the outgoing record
  mrb_tx_seq u_tx_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (start),
    .advance (advance),
    .busy    (tx_busy),
    .offset  (tx_off)
  );
  // offset tracker for the incoming record
  mrb_rx_track u_rx_track (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (in_valid),
    .in_last   (in_last),
    .offset    (rx_off),
    .frame_end (rx_end),
    .frame_bad (rx_bad)
  );
  // outgoing byte register, held while the write path stalls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_data  <= 8'h00;
      out_last  <= 1'b0;
    end else if (advance) begin
      out_valid <= 1'b1;
      out_data  <= gen_sel ? gen_byte(tx_off) : cal_byte(tx_off); // RULE21
      out_last  <= (tx_off == mrb_pkg::REC_LAST);
    end else if (out_ready) begin
      out_valid <= 1'b0;
      out_last  <= 1'b0;
    end
  end

  // software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < mrb_pkg::CAL_WORDS; i++) begin
        cal_addr[i] <= 32'h0;
      end
      flex_on     <= 1'b0;
      gen_sel     <= 1'b0;
      rx_gen      <= 1'b0;
      disc_status <= 2'b00;
      app_code    <= 8'h00;
      phys_code   <= 8'h00;
      part_ext    <= 8'h00;
      l0_last     <= 24'h0;
      l1_last     <= 24'h0;
      mfr1_hi     <= 32'h0;
      mfr1_lo     <= 16'h0;
      mfr2_hi     <= 32'h0;
      mfr2_lo     <= 16'h0;
      shift_start <= 32'h0;
      prerec      <= 6'h00;
    end else if (wr_en) begin
      if (paddr == mrb_pkg::A_CTRL) begin
        if (!tx_busy) begin
          gen_sel <= pwdata[mrb_pkg::CTRL_GEN];
        end
        rx_gen <= pwdata[mrb_pkg::CTRL_RXGEN];
      end else if (in_cal(paddr)) begin
        cal_addr[3'(paddr[7:2] - 6'd2)] <= pwdata;
      end else if (paddr == mrb_pkg::A_FLEX) begin
        flex_on <= pwdata[0];
      end else if (paddr == mrb_pkg::A_DISC) begin
        disc_status <= pwdata[1:0]; // RULE8
        app_code    <= pwdata[15:8];
        phys_code   <= pwdata[23:16];
        part_ext    <= pwdata[31:24];
      end else if (paddr == mrb_pkg::A_L0_LAST) begin
        l0_last <= pwdata[23:0];
      end else if (paddr == mrb_pkg::A_L1_LAST) begin
        l1_last <= pwdata[23:0];
      end else if (paddr == mrb_pkg::A_MFR1_HI) begin
        mfr1_hi <= pwdata;
      end else if (paddr == mrb_pkg::A_MFR1_LO) begin
        mfr1_lo <= pwdata[15:0];
      end else if (paddr == mrb_pkg::A_MFR2_HI) begin
        mfr2_hi <= pwdata;
      end else if (paddr == mrb_pkg::A_MFR2_LO) begin
        mfr2_lo <= pwdata[15:0];
      end else if (paddr == mrb_pkg::A_SHIFT) begin
        shift_start <= pwdata;
      end else if (paddr == mrb_pkg::A_PREREC) begin
        prerec <= pwdata[5:0];
      end
    end
  end

  // capture of incoming status fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_fmt_hi <= 8'h00;
      rx_status <= 8'h00;
      rx_code   <= 8'h00;
    end else if (in_valid && rx_gen) begin
      if (rx_off == 11'd0) begin
        rx_fmt_hi <= in_data;
      end
      if (rx_off == 11'd2) begin
        rx_status <= in_data;
      end
      if (rx_off == mrb_pkg::O_PRECODE) begin
        rx_code <= in_data;
      end
    end
  end

  // sticky check results; a new error wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_flag   <= 1'b0;
      err_fmt    <= 1'b0;
      err_status <= 1'b0;
      err_code   <= 1'b0;
      err_frame  <= 1'b0;
      chk_done   <= 1'b0;
    end else begin
      if (wr_en && paddr == mrb_pkg::A_STATUS) begin
        err_flag   <= err_flag   & ~pwdata[2];
        err_fmt    <= err_fmt    & ~pwdata[3];
        err_status <= err_status & ~pwdata[4];
        err_code   <= err_code   & ~pwdata[5];
        err_frame  <= err_frame  & ~pwdata[6];
        chk_done   <= chk_done   & ~pwdata[1];
      end
      if (rx_end) begin
        chk_done <= 1'b1;
      end
      if (rx_bad) begin
        err_frame <= 1'b1;
      end
      if (in_valid && !rx_gen && rx_off == 11'd0 &&
          in_data != mrb_pkg::FLEX_OFF && in_data != mrb_pkg::FLEX_ON) begin
        err_flag <= 1'b1; // RULE1
      end
      if (in_valid && rx_gen && rx_off == 11'd1 &&
          {rx_fmt_hi, in_data} != mrb_pkg::FMT_CODE) begin
        err_fmt <= 1'b1; // RULE7
      end
      if (in_valid && rx_gen && rx_off == 11'd2 && in_data > mrb_pkg::ST_FINAL) begin
        err_status <= 1'b1; // RULE8
      end
      // unique id bytes are never examined; code byte only checked when not finalized
      if (in_valid && rx_gen && rx_off == mrb_pkg::O_PRECODE &&
          rx_status != mrb_pkg::ST_FINAL && (in_data[0] || in_data[7:4] != 4'h0)) begin
        err_code <= 1'b1; // RULE10 RULE14 RULE16
      end
    end
  end

  // apb answer: ready in the first access cycle, unmapped reads error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (setup && !pwrite) begin
        if (paddr == mrb_pkg::A_CTRL) begin
          prdata <= {29'h0, rx_gen, gen_sel, 1'b0};
        end else if (paddr == mrb_pkg::A_STATUS) begin
          prdata <= {25'h0, err_frame, err_code, err_status, err_fmt, err_flag,
                     chk_done, tx_busy};
        end else if (in_cal(paddr)) begin
          prdata <= cal_addr[3'(paddr[7:2] - 6'd2)];
        end else if (paddr == mrb_pkg::A_FLEX) begin
          prdata <= {31'h0, flex_on};
        end else if (paddr == mrb_pkg::A_DISC) begin
          prdata <= {part_ext, phys_code, app_code, 6'h00, disc_status};
        end else if (paddr == mrb_pkg::A_L0_LAST) begin
          prdata <= {8'h00, l0_last};
        end else if (paddr == mrb_pkg::A_L1_LAST) begin
          prdata <= {8'h00, l1_last};
        end else if (paddr == mrb_pkg::A_MFR1_HI) begin
          prdata <= mfr1_hi;
        end else if (paddr == mrb_pkg::A_MFR1_LO) begin
          prdata <= {16'h0, mfr1_lo};
        end else if (paddr == mrb_pkg::A_MFR2_HI) begin
          prdata <= mfr2_hi;
        end else if (paddr == mrb_pkg::A_MFR2_LO) begin
          prdata <= {16'h0, mfr2_lo};
        end else if (paddr == mrb_pkg::A_SHIFT) begin
          prdata <= shift_start;
        end else if (paddr == mrb_pkg::A_PREREC) begin
          prdata <= {26'h0, prerec};
        end else if (paddr == mrb_pkg::A_LI_START) begin
          prdata <= {8'h00, li_start}; // RULE18
        end else if (paddr == mrb_pkg::A_MID1_END) begin
          prdata <= {8'h00, mid1_end}; // RULE19
        end else if (paddr == mrb_pkg::A_LO_START) begin
          prdata <= {lo_end, 8'h00} | 32'h0; // RULE20
        end else if (paddr == mrb_pkg::A_RX_INFO) begin
          prdata <= {15'h0, rx_status != mrb_pkg::ST_FINAL, rx_status,
                     rx_status == mrb_pkg::ST_FINAL ? 8'h00 : rx_code}; // RULE16
        end else begin
          pslverr <= 1'b1;
        end
      end else if (setup && pwrite) begin
        if (!(paddr <= mrb_pkg::A_PREREC && paddr[1:0] == 2'b00)) begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule // mrb_builder

// ==== verilog/mrb_pkg.sv ====
// Overview of operation
// RULE1: flexible test flag byte is 00 or 02
// RULE2: bytes 1-8 hold flexible test addresses
// RULE3: bytes 9-16 hold inner test addresses
// RULE4: bytes 17-24 hold fixed outer test addresses
// RULE5: bytes 25-28 hold optional inner layer-1 address
// RULE6: calibration record bytes 29 onward are zero
// RULE7: general record starts with format code 0004
// RULE8: disc status byte only 00 to 03
// RULE9: general record byte 3 is zero
// RULE10: unique disc id content is ignored
// RULE11: prepit block tags 01-05 at fixed offsets
// RULE12: prepit copy carries codes, addresses, maker id
// RULE13: shifted middle start or zero when unused
// RULE14: byte 90 bit 0 is zero
// RULE15: byte 90 bits 1-3 mark prerecorded zones
// RULE16: finalized disc invalidates prerecorded fields
// RULE17: four boundary addresses at offsets 92-107
// RULE18: lead-in range start depends on burst area
// RULE19: middle zone limits by disc size
// RULE20: lead-out start is layer-1 last minus 33
// RULE21: big-endian fields, ascending byte order
package mrb_pkg;
  localparam int          REC_BYTES   = 2048;
  localparam logic [10:0] REC_LAST    = 11'h7ff;
  // apb register byte addresses
  localparam logic [7:0] A_CTRL      = 8'h00;
  localparam logic [7:0] A_STATUS    = 8'h04;
  localparam logic [7:0] A_CAL0      = 8'h08;
  localparam logic [7:0] A_CAL6      = 8'h20;
  localparam logic [7:0] A_FLEX      = 8'h24;
  localparam logic [7:0] A_DISC      = 8'h28;
  localparam logic [7:0] A_L0_LAST   = 8'h2c;
  localparam logic [7:0] A_L1_LAST   = 8'h30;
  localparam logic [7:0] A_MFR1_HI   = 8'h34;
  localparam logic [7:0] A_MFR1_LO   = 8'h38;
  localparam logic [7:0] A_MFR2_HI   = 8'h3c;
  localparam logic [7:0] A_MFR2_LO   = 8'h40;
  localparam logic [7:0] A_SHIFT     = 8'h44;
  localparam logic [7:0] A_PREREC    = 8'h48;
  localparam logic [7:0] A_LI_START  = 8'h4c;
  localparam logic [7:0] A_MID1_END  = 8'h50;
  localparam logic [7:0] A_LO_START  = 8'h54;
  localparam logic [7:0] A_RX_INFO   = 8'h58;
  localparam int         CAL_WORDS   = 7;
  // control and pre-recordable range bit positions
  localparam int CTRL_START  = 0;
  localparam int CTRL_GEN    = 1;
  localparam int CTRL_RXGEN  = 2;
  localparam int PRE_SHIFT   = 0;
  localparam int PRE_LEADIN  = 1;
  localparam int PRE_MIDDLE  = 2;
  localparam int PRE_LEADOUT = 3;
  localparam int PRE_NARROW_BURST_CUT_AREA    = 4;
  localparam int PRE_SMALL   = 5;
  // record codes
  localparam logic [7:0]  FLEX_OFF    = 8'h00;
  localparam logic [7:0]  FLEX_ON     = 8'h02;
  localparam logic [15:0] FMT_CODE    = 16'h0004;
  localparam logic [7:0]  ST_FINAL    = 8'h03;
  // offsets in the general record and the end of the calibration record addresses
  localparam logic [10:0] O_PREPIT    = 11'd22;
  localparam logic [10:0] O_PREPIT_E  = 11'd85;
  localparam logic [10:0] O_SHIFT     = 11'd86;
  localparam logic [10:0] O_PRECODE   = 11'd90;
  localparam logic [10:0] O_BOUND     = 11'd92;
  localparam logic [10:0] O_BOUND_E   = 11'd107;
  localparam logic [10:0] O_CAL_E     = 11'd28;
  // pre-recordable range limits
  localparam logic [23:0] LI_START    = 24'hffdbbb;
  localparam logic [23:0] LI_START_NB = 24'hffd2a4;
  localparam logic [23:0] LI_END      = 24'hffd000;
  localparam logic [23:0] MID0_END_L  = 24'hfdcf6d;
  localparam logic [23:0] MID0_END_S  = 24'hff2f22;
  localparam logic [23:0] MID1_ST_L   = 24'h023573;
  localparam logic [23:0] MID1_ST_S   = 24'h00d4d6;
  localparam logic [23:0] MID_BACK    = 24'h000008;
  localparam logic [23:0] LO_BACK     = 24'h000021;
  localparam logic [23:0] LO_END      = 24'h002942;
  localparam logic [23:0] LO_END_NB   = 24'h002f99;
  typedef enum logic [1:0] {
    MRB_IDLE = 2'b01,
    MRB_SEND = 2'b10
  } mrb_tx_e;
endpackage

// ==== verilog/mrb_tx_seq.sv ====
`timescale 1ns/1ns
// walks the record offsets once per start, advancing on each accepted byte
module mrb_tx_seq (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control
  input  wire logic        start,
  input  wire logic        advance,
  // sequence state
  output logic             busy,
  output logic [10:0]      offset
);
  mrb_pkg::mrb_tx_e state;

  // state and offset counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state  <= mrb_pkg::MRB_IDLE;
      offset <= 11'h000;
    end else begin
      case (state)
        mrb_pkg::MRB_IDLE: begin
          if (start) begin
            state  <= mrb_pkg::MRB_SEND;
            offset <= 11'h000;
          end
        end
        mrb_pkg::MRB_SEND: begin
          if (advance) begin
            if (offset == mrb_pkg::REC_LAST) begin
              state <= mrb_pkg::MRB_IDLE;
            end else begin
              offset <= offset + 11'h001; // RULE21
            end
          end
        end
        default: state <= mrb_pkg::MRB_IDLE;
      endcase
    end
  end

  assign busy = (state == mrb_pkg::MRB_SEND);
endmodule // mrb_tx_seq

// ==== verilog/mrb_rx_track.sv ====
`timescale 1ns/1ns
// tracks the offset of each incoming record byte and flags bad framing
module mrb_rx_track (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // incoming byte strobe
  input  wire logic        in_valid,
  input  wire logic        in_last,
  // tracking results
  output logic [10:0]      offset,
  output logic             frame_end,
  output logic             frame_bad
);
  // offset advances per byte, restarts after a last byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset <= 11'h000;
    end else if (in_valid) begin
      offset <= in_last ? 11'h000 : offset + 11'h001;
    end
  end

  assign frame_end = in_valid && in_last;
  assign frame_bad = in_valid && (in_last != (offset == mrb_pkg::REC_LAST));
endmodule // mrb_rx_track

// ==== verif/mrb_builder_assertions.sv ====
`timescale 1ns/1ns
// watches the apb answers and the outgoing record stream
module mrb_builder_assertions (
  // clock and reset
  input logic        pclk, presetn,
  // apb slave
  input logic        psel, penable, pwrite, pready, pslverr,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata, prdata,
  // record streams
  input logic        out_valid, out_last, out_ready, in_valid, in_last,
  input logic [7:0]  out_data, in_data
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [10:0] sent;
  // counts accepted bytes so the last flag can be placed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sent <= '0;
    else if (out_valid && out_ready) sent <= sent + 11'd1;
  end
  a_setup_gets_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_quiet: assert property (!pready || pwrite |-> prdata == 32'h0)
    else $error("read data outside a read answer");
  a_bad_addr_err: assert property (pready && (paddr[1:0] != 2'b00 || paddr > 8'h58) |-> pslverr)
    else $error("unmapped access not refused");
  a_good_read_ok: assert property (pready && !pwrite && paddr[1:0] == 2'b00 && paddr <= 8'h58
    |-> !pslverr) else $error("mapped read refused");
  a_ro_write_err: assert property (pready && pwrite && paddr > 8'h48 |-> pslverr)
    else $error("read-only write not refused");
  a_byte_held: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stalled byte changed");
  a_last_place: assert property (out_valid && out_ready |-> out_last == (sent == 11'h7ff))
    else $error("last flag misplaced");
endmodule // mrb_builder_assertions
bind mrb_builder mrb_builder_assertions u_mrb_builder_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .out_valid(out_valid), .out_last(out_last), .out_ready(out_ready), .in_valid(in_valid),
  .in_last(in_last), .out_data(out_data), .in_data(in_data));

// ==== verif/mrb_medium.sv ====
`timescale 1ns/1ns
// stands in for the medium: takes the write stream, plays records back
module mrb_medium (
  // clock and reset
  input  logic       pclk, presetn,
  // write stream
  input  logic       out_valid, out_last,
  input  logic [7:0] out_data,
  output logic       out_ready,
  // read stream
  output logic       in_valid, in_last,
  output logic [7:0] in_data
);
  logic [7:0] mem [0:2047];
  int wp = 0;
  int got = 0;
  initial begin
    in_valid = 0;
    in_last = 0;
    in_data = 8'h5a;
    out_ready = 0;
  end
  // takes bytes, stalling at random
  always @(posedge pclk) begin
    out_ready <= ($urandom % 4) != 0;
    if (out_valid && out_ready) begin
      mem[wp] <= out_data;
      wp <= out_last ? 0 : wp + 1;
      got <= got + int'(out_last);
    end
  end
  // plays the captured record back, one byte per cycle, id scrambled
  task play(input int bo, input logic [7:0] bv);
    for (int i = 0; i < 2048; i++) begin
      @(posedge pclk);
      in_valid <= 1;
      in_last <= i == 2047;
      in_data <= i == bo ? bv : (i > 3 && i < 22) ? 8'($urandom) : mem[i];
    end
    @(posedge pclk);
    in_valid <= 0;
    in_last <= 0;
    in_data <= ~in_data;
  endtask
endmodule // mrb_medium

// ==== verif/tb_mrb_builder.sv ====
`timescale 1ns/1ns
// builds records over apb, checks them, plays them back damaged
module tb_mrb_builder;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0] paddr = 0, out_data, in_data;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, out_valid, out_last, out_ready, in_valid, in_last;
  logic [31:0] r [0:16];
  logic [0:107][7:0] ev;
  int bad_count = 0, checked = 0;
  mrb_builder u_mrb_builder (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last), .out_ready(out_ready),
    .in_valid(in_valid), .in_data(in_data), .in_last(in_last));
  mrb_medium u_mrb_medium (
    .pclk(pclk), .presetn(presetn), .out_valid(out_valid), .out_last(out_last),
    .out_data(out_data), .out_ready(out_ready), .in_valid(in_valid), .in_last(in_last),
    .in_data(in_data));
  always #5 pclk = ~pclk;
  task results;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task to;
    bad_count++;
    $display("ERROR %0t wait ran out", $time);
    results();
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one apb transfer, held until ready
  task apb(input bit w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 9);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1) to();
  endtask
  // expected record head from the register values
  function void mk(input bit g);
    logic [7:0] p;
    p = r[16][7:0];
    ev = '0;
    ev[0] = r[7][0] ? 8'h02 : 8'h00;
    ev[1:28] = {r[0], r[1], r[2], r[3], r[4], r[5], r[6]};
    if (g) begin
      ev[0:28] = '0;
      ev[0:3] = {16'h0004, 6'h0, r[8][1:0], 8'h00};
      ev[22:28] = {8'h01, r[8][15:8], r[8][23:16], r[9][23:0], r[8][31:24]};
      ev[30] = 8'h02;
      ev[33:35] = r[10][23:0];
      ev[38:44] = {8'h03, r[11], r[12][15:0]};
      ev[46:52] = {8'h04, r[13], r[14][15:0]};
      ev[54] = 8'h05;
      if (p[0]) ev[86:89] = r[15];
      ev[90] = {4'h0, p[3:1], 1'b0};
      if (p[1]) ev[92:95] = 32'h00ffd000;
      if (p[2]) ev[96:103] = {8'h0, p[5] ? 56'hff2f220000d4d6 : 56'hfdcf6d00023573};
      if (p[3]) ev[104:107] = {8'h0, r[10][23:0] - 24'h21};
    end
  endfunction
  task build(input bit g);
    int n, k;
    k = u_mrb_medium.got;
    n = 0;
    apb(1, 8'h00, {29'h0, g, g, 1'b1});
    while (u_mrb_medium.got == k && n < 9000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 9000) to();
    mk(g);
    for (int i = 0; i < 2048; i++)
      if (!g || i < 4 || i > 21) chk(u_mrb_medium.mem[i], i < 108 ? ev[i] : 0);
  endtask
  // plays a record back with one byte replaced, then reads and clears status
  task rx(input int o, input logic [7:0] v, input logic [31:0] e);
    u_mrb_medium.play(o, v);
    repeat (2) @(posedge pclk);
    apb(0, 8'h04, 0);
    chk(rd, e);
    apb(1, 8'h04, 32'h7e);
  endtask
  initial begin
    void'($urandom(32'h8668));
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, 8'h04, 0);
    chk(rd, 0);
    apb(0, 8'h5c, 0);
    chk(32'(er), 1);
    apb(1, 8'h4c, 0);
    chk(32'(er), 1);
    $display("test bus corners done");
    for (int s = 0; s < 4; s++) begin
      foreach (r[i]) r[i] = $urandom;
      r[7] &= 32'h1;
      r[8][1:0] = 2'(s);
      r[16] &= 32'h3f;
      foreach (r[i]) apb(1, 8'(8 + 4 * i), r[i]);
      build(0);
      rx(0, s[0] ? 8'h02 : 8'h03, s[0] ? 2 : 6);
      build(1);
      rx(90, 8'h01, s == 3 ? 2 : 34);
      apb(0, 8'h58, 0);
      chk(rd, {15'h0, s != 3, 8'(s), s == 3 ? 8'h0 : 8'h01});
      apb(0, 8'h4c, 0);
      chk(rd, {8'h0, r[16][4] ? 24'hffd2a4 : 24'hffdbbb});
      apb(0, 8'h50, 0);
      chk(rd, {8'h0, ~(r[9][23:0] - 24'h8)});
      apb(0, 8'h54, 0);
      chk(rd, {r[16][4] ? 24'h002f99 : 24'h002942, 8'h0});
      $display("test %0d done", s);
    end
    rx(2, 8'h04, 18);
    rx(1, 8'h05, 10);
    $display("test bad fields done");
    results();
  end
endmodule // tb_mrb_builder
